// *** core/acrb_pkg.sv ***
// constants and types for the converter configuration register bank
package acrb_pkg;

  typedef logic [15:0] acrb_word_t;
  typedef logic [6:0] acrb_addr_t;

  // serial frame
  localparam int ADDR_BITS = 8;
  localparam int FRAME_BITS = 24;

  // register offsets
  localparam acrb_addr_t ADDR_CORR_A = 7'h03;
  localparam acrb_addr_t ADDR_SYNC_PRIMARY = 7'h0e;
  localparam acrb_addr_t ADDR_SYNC_REFERENCE = 7'h0f;
  localparam acrb_addr_t ADDR_CORR_B = 7'h1a;
  localparam acrb_addr_t ADDR_TEMPERATURE = 7'h2b;
  localparam acrb_addr_t ADDR_SOFT_RESET = 7'h2c;
  localparam acrb_addr_t ADDR_SLEEP_SELECT = 7'h37;
  localparam acrb_addr_t ADDR_BIAS_POWER = 7'h38;
  localparam acrb_addr_t ADDR_OUTPUT_DRIVER = 7'h3a;
  localparam acrb_addr_t ADDR_LANE_MASK_A = 7'h66;
  localparam acrb_addr_t ADDR_LANE_MASK_B = 7'h67;

  // stored registers: index order, offset, reset, writable bits, fixed ones
  localparam int REG_COUNT = 9;
  localparam int IDX_CORR_A = 0;
  localparam int IDX_CORR_B = 1;
  localparam int IDX_SYNC_P = 2;
  localparam int IDX_SYNC_R = 3;
  localparam int IDX_SLEEP = 4;
  localparam int IDX_BIAS = 5;
  localparam int IDX_DRIVER = 6;
  localparam int IDX_MASK_A = 7;
  localparam int IDX_MASK_B = 8;
  localparam acrb_addr_t REG_ADDR [REG_COUNT] = '{ADDR_CORR_A, ADDR_CORR_B,
    ADDR_SYNC_PRIMARY, ADDR_SYNC_REFERENCE, ADDR_SLEEP_SELECT, ADDR_BIAS_POWER,
    ADDR_OUTPUT_DRIVER, ADDR_LANE_MASK_A, ADDR_LANE_MASK_B};
  localparam acrb_word_t REG_RST [REG_COUNT] = '{16'h4b18, 16'h4b18, 16'haaa8,
    16'ha000, 16'h0000, 16'hffff, 16'h081b, 16'hffff, 16'hffff};
  localparam acrb_word_t REG_MASK [REG_COUNT] = '{16'h4b18, 16'h4b18, 16'hfffc,
    16'hf070, 16'hfc00, 16'hfff0, 16'hfe1b, 16'hffff, 16'hffff};
  localparam acrb_word_t REG_ONES [REG_COUNT] = '{16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h000f, 16'h0000, 16'h0000, 16'h0000};

  // software reset key
  localparam acrb_word_t SOFT_RESET_KEY = 16'hd2f0;

  // field positions
  localparam int CORR_START_BIT = 14;
  localparam int VREF_LSB = 4;
  localparam logic [2:0] VREF_LAST_INTERNAL = 3'h4;
  localparam int SLEEP_LSB = 10;
  localparam int TRIM_LSB = 7;
  localparam int BIAS_BIT = 6;
  localparam int SYNC_BUF_BIT = 5;
  localparam int UNUSED_BUF_BIT = 4;
  localparam int DRIVE_LSB = 13;
  localparam int SWITCH_LSB = 11;
  localparam int TERM_LSB = 9;
  localparam int CLK_A_BIT = 4;
  localparam int CLK_B_BIT = 3;
  localparam int OVR_A_BIT = 1;
  localparam int OVR_B_BIT = 0;

  // sleep selection codes
  localparam logic [5:0] SLEEP_CODE_STANDBY = 6'h20;
  localparam logic [5:0] SLEEP_CODE_DEEP = 6'h30;
  localparam logic [5:0] SLEEP_CODE_LIGHT = 6'h35;

  typedef enum logic [3:0] {
    SYNC_OFF = 4'h1, SYNC_ONESHOT = 4'h2, SYNC_PINS = 4'h4, SYNC_UNSUPPORTED = 4'h8
  } acrb_sync_t;
  typedef enum logic [3:0] {
    SLP_SHUTDOWN = 4'h1, SLP_STANDBY = 4'h2, SLP_DEEP = 4'h4, SLP_LIGHT = 4'h8
  } acrb_sleep_t;
  typedef enum logic [2:0] {
    PWR_RUN = 3'h1, PWR_SLEEP = 3'h2, PWR_WAKE = 3'h4
  } acrb_pwr_t;

  // wake times
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real WAKE_SHUTDOWN_MS = 2.5;
  localparam real WAKE_STANDBY_US = 100.0;
  localparam real WAKE_DEEP_US = 20.0;
  localparam real WAKE_LIGHT_US = 2.0;
  localparam int WAKE_SHUTDOWN_CYC = int'($ceil(WAKE_SHUTDOWN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int WAKE_STANDBY_CYC = int'($ceil(WAKE_STANDBY_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int WAKE_DEEP_CYC = int'($ceil(WAKE_DEEP_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int WAKE_LIGHT_CYC = int'($ceil(WAKE_LIGHT_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int WAKE_CNT_W = 19;

endpackage

// *** core/acrb_reg_if.sv ***
// register access carrier between serial port and register bank
`timescale 1ns/10ps
interface acrb_reg_if;
  logic wr_stb;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

// *** core/acrb_serial_port.sv ***
// three-wire serial programming port sampled on the system clock
`timescale 1ns/10ps
module acrb_serial_port
  import acrb_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic sclk_i, // serial clock pin
  input wire logic sdenb_n_i, // serial enable, low active
  input wire logic sdio_i, // data pin level
  output logic sdio_o, // data pin drive value
  output logic sdio_oe_o, // data pin drive enable
  acrb_reg_if.port rp // register access
);
  logic [2:0] s1_q, s2_q;
  logic sclk_prev_q;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] in_q, in_d;
  logic [15:0] out_q, out_d;
  logic rw_q, rw_d;
  logic [6:0] addr_q, addr_d;
  logic load_q, load_d;
  logic wr_q, wr_d;
  logic [15:0] wdata_q, wdata_d;
  logic dout_q, dout_d;
  logic oe_q, oe_d;
  logic rise, fall, sel;

  // pin synchronisers and edge history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= 3'h2;
      s2_q <= 3'h2;
      sclk_prev_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= {sdio_i, sdenb_n_i, sclk_i};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[0];
    end
  end

  assign rise = s2_q[0] & ~sclk_prev_q;
  assign fall = ~s2_q[0] & sclk_prev_q;
  assign sel = ~s2_q[1];

  // frame shifter: direction bit and 7 address bits then 16 data bits
  always_comb begin
    cnt_d = cnt_q;
    in_d = in_q;
    out_d = out_q;
    rw_d = rw_q;
    addr_d = addr_q;
    load_d = 1'b0;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    dout_d = dout_q;
    oe_d = oe_q;
    if (!sel) begin
      cnt_d = 5'h00;
      oe_d = 1'b0;
    end else if (rise && cnt_q < 5'(FRAME_BITS)) begin
      in_d = {in_q[14:0], s2_q[2]};
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == 5'(ADDR_BITS - 1)) begin
        rw_d = in_q[6];
        addr_d = {in_q[5:0], s2_q[2]};
        load_d = in_q[6];
      end
      if (cnt_q == 5'(FRAME_BITS - 1) && !rw_q) begin
        wr_d = 1'b1;
        wdata_d = {in_q[14:0], s2_q[2]};
      end
    end else if (fall && rw_q && cnt_q >= 5'(ADDR_BITS)) begin
      // read data changes on falling edges, sampled by the controller on rising
      dout_d = out_q[15];
      out_d = {out_q[14:0], 1'b0};
      oe_d = cnt_q < 5'(FRAME_BITS);
    end
    if (load_q) begin
      out_d = rp.rdata;
    end
  end

  // frame state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 5'h00;
      in_q <= 16'h0000;
      out_q <= 16'h0000;
      rw_q <= 1'b0;
      addr_q <= 7'h00;
      load_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= 16'h0000;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      in_q <= in_d;
      out_q <= out_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      load_q <= load_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign rp.wr_stb = wr_q;
  assign rp.addr = addr_q;
  assign rp.wdata = wdata_q;
  assign sdio_o = dout_q;
  assign sdio_oe_o = oe_q;

endmodule // acrb_serial_port

// *** core/acrb_top.sv ***
// configuration and status register bank of a dual-channel converter
// Behaviour
// - channel a start bit high holds offset at zero, gain at one; low runs loop
// - channel b start bit behaves the same, default one
// - primary sync field repeats a two-bit code: off, one-shot, pins, unsupported
// - reference sync field decodes 0000,0101,1010,1111 and combines with primary
// - reference select picks five internal voltages, other codes external
// - temperature reads as nine bits, upper bits zero
// - key pattern to reset register restores all defaults, register reads zero
// - sleep field decodes shutdown, standby, deep sleep, light sleep
// - sleep applies only while enable pin low; wake takes state-specific time
// - bias enable bit powers internal bias
// - sync buffer enable bit powers the sync input buffer
// - bit four controls the unused input buffer low-power option
// - channel a lane mask powers down lanes whose bit is zero
// - channel b lane mask powers down lanes whose bit is zero
`timescale 1ns/10ps
module acrb_top
  import acrb_pkg::*;
#(
  parameter int WAKE_SHUT_CYCLES = WAKE_SHUTDOWN_CYC,
  parameter int WAKE_STBY_CYCLES = WAKE_STANDBY_CYC
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic ce_i, // clock enable
  input wire logic sclk_i, // serial clock pin
  input wire logic sdenb_n_i, // serial enable pin, low
  input wire logic sdio_i, // serial data pin in
  output logic sdio_o, // serial data pin out
  output logic sdio_oe_o, // serial data drive enable
  input wire logic enable_i, // enable pin
  input wire logic [8:0] temp_i, // temperature sample
  output logic corr_hold_a_o, // channel a loop held
  output logic corr_hold_b_o, // channel b loop held
  output logic [3:0] sync_mode_o, // one-hot sync source
  output logic [2:0] vref_sel_o, // reference code
  output logic vref_ext_o, // external reference
  output logic [3:0] sleep_state_o, // active sleep state
  output logic powered_o, // awake and settled
  output logic [8:0] performance_trim_bits_o, // trim bits
  output logic bias_en_o, // internal bias on
  output logic sync_buf_en_o, // sync input buffer on
  output logic unused_buffer_disable_o, // low-power buffer option
  output logic [2:0] drive_current_o, // drive current code
  output logic [1:0] driver_switch_o, // driver range
  output logic [1:0] termination_o, // termination code
  output logic chan_a_clock_out_on_o, // channel a clock buffer
  output logic chan_b_clock_out_on_o, // channel b clock buffer
  output logic chan_a_overrange_out_on_o, // channel a over-range buffer
  output logic chan_b_overrange_out_on_o, // channel b over-range buffer
  output logic [15:0] lane_mask_a_o, // channel a lane power
  output logic [15:0] lane_mask_b_o // channel b lane power
);

  // offset to stored index, or REG_COUNT when unmapped
  function automatic int reg_index(input acrb_addr_t a);
    int r;
    r = REG_COUNT;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (REG_ADDR[i] == a) begin
        r = i;
      end
    end
    return r;
  endfunction

  // two-bit sync code to mode
  function automatic acrb_sync_t sync_code(input logic [1:0] c);
    unique case (c)
      2'h0: sync_code = SYNC_OFF;
      2'h1: sync_code = SYNC_ONESHOT;
      2'h2: sync_code = SYNC_PINS;
      2'h3: sync_code = SYNC_UNSUPPORTED;
    endcase
  endfunction

  acrb_reg_if rp ();

  acrb_serial_port u_port (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .sdenb_n_i(sdenb_n_i),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o),
    .rp(rp.port)
  );

  acrb_word_t regs_q [REG_COUNT];
  acrb_word_t regs_d [REG_COUNT];
  int widx, ridx;
  logic soft_rst;

  assign widx = reg_index(rp.addr);
  assign ridx = widx;
  assign soft_rst = rp.wr_stb && rp.addr == ADDR_SOFT_RESET && rp.wdata == SOFT_RESET_KEY;

  // register writes and software reset
  always_comb begin
    regs_d = regs_q;
    if (soft_rst) begin
      regs_d = REG_RST;
    end else if (rp.wr_stb && widx < REG_COUNT) begin
      regs_d[widx] = (rp.wdata & REG_MASK[widx]) | REG_ONES[widx];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      regs_q <= REG_RST;
    end else if (ce_i) begin
      regs_q <= regs_d;
    end
  end

  // read mux; reset register always reads zero
  always_comb begin
    rp.rdata = 16'h0000;
    if (rp.addr == ADDR_TEMPERATURE) begin
      rp.rdata = {7'h00, temp_i};
    end else if (ridx < REG_COUNT) begin
      rp.rdata = regs_q[ridx];
    end
  end

  // enable pin synchroniser
  logic en_s1_q, en_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_s1_q <= 1'b1;
      en_q <= 1'b1;
    end else if (ce_i) begin
      en_s1_q <= enable_i;
      en_q <= en_s1_q;
    end
  end

  // decoded configuration
  acrb_sync_t sync_p, sync_r, sync_mode;
  acrb_sleep_t sleep_sel;
  logic [13:0] sync_pf;
  logic [3:0] sync_rf;
  logic [5:0] sleep_f;

  always_comb begin
    sync_pf = regs_q[IDX_SYNC_P][15:2];
    sync_rf = regs_q[IDX_SYNC_R][15:12];
    sync_p = SYNC_UNSUPPORTED;
    sync_r = SYNC_UNSUPPORTED;
    if (sync_pf == {7{sync_pf[1:0]}}) begin
      sync_p = sync_code(sync_pf[1:0]);
    end
    if (sync_rf == {2{sync_rf[1:0]}}) begin
      sync_r = sync_code(sync_rf[1:0]);
    end
    sync_mode = (sync_p == sync_r) ? sync_p : SYNC_UNSUPPORTED;
    sleep_f = regs_q[IDX_SLEEP][SLEEP_LSB+:6];
    unique case (sleep_f)
      SLEEP_CODE_STANDBY: sleep_sel = SLP_STANDBY;
      SLEEP_CODE_DEEP: sleep_sel = SLP_DEEP;
      SLEEP_CODE_LIGHT: sleep_sel = SLP_LIGHT;
      default: sleep_sel = SLP_SHUTDOWN;
    endcase
  end

  // power state machine and wake timer
  acrb_pwr_t pwr_q, pwr_d;
  acrb_sleep_t slp_q, slp_d;
  logic [WAKE_CNT_W-1:0] wcnt_q, wcnt_d;
  logic [3:0] sleep_state_d;
  logic powered_d;

  always_comb begin
    pwr_d = pwr_q;
    slp_d = slp_q;
    wcnt_d = wcnt_q;
    unique case (pwr_q)
      PWR_RUN: begin
        if (!en_q) begin
          pwr_d = PWR_SLEEP;
          slp_d = sleep_sel;
        end
      end
      PWR_SLEEP: begin
        if (en_q) begin
          pwr_d = PWR_WAKE;
          unique case (slp_q)
            SLP_SHUTDOWN: wcnt_d = WAKE_CNT_W'(WAKE_SHUT_CYCLES - 1);
            SLP_STANDBY: wcnt_d = WAKE_CNT_W'(WAKE_STBY_CYCLES - 1);
            SLP_DEEP: wcnt_d = WAKE_CNT_W'(WAKE_DEEP_CYC - 1);
            SLP_LIGHT: wcnt_d = WAKE_CNT_W'(WAKE_LIGHT_CYC - 1);
          endcase
        end
      end
      PWR_WAKE: begin
        if (!en_q) begin
          pwr_d = PWR_SLEEP;
          slp_d = sleep_sel;
        end else if (wcnt_q == '0) begin
          pwr_d = PWR_RUN;
        end else begin
          wcnt_d = wcnt_q - 1'b1;
        end
      end
    endcase
    sleep_state_d = (pwr_d == PWR_SLEEP) ? slp_d : 4'h0;
    powered_d = pwr_d == PWR_RUN;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_q <= PWR_RUN;
      slp_q <= SLP_SHUTDOWN;
      wcnt_q <= '0;
      sleep_state_o <= 4'h0;
      powered_o <= 1'b1;
    end else if (ce_i) begin
      pwr_q <= pwr_d;
      slp_q <= slp_d;
      wcnt_q <= wcnt_d;
      sleep_state_o <= sleep_state_d;
      powered_o <= powered_d;
    end
  end

  // registered control outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      corr_hold_a_o <= 1'b1;
      corr_hold_b_o <= 1'b1;
      sync_mode_o <= SYNC_PINS;
      vref_sel_o <= 3'h0;
      vref_ext_o <= 1'b0;
      performance_trim_bits_o <= 9'h1ff;
      bias_en_o <= 1'b1;
      sync_buf_en_o <= 1'b1;
      unused_buffer_disable_o <= 1'b1;
      drive_current_o <= 3'h0;
      driver_switch_o <= 2'h1;
      termination_o <= 2'h0;
      chan_a_clock_out_on_o <= 1'b1;
      chan_b_clock_out_on_o <= 1'b1;
      chan_a_overrange_out_on_o <= 1'b1;
      chan_b_overrange_out_on_o <= 1'b1;
      lane_mask_a_o <= 16'hffff;
      lane_mask_b_o <= 16'hffff;
    end else if (ce_i) begin
      corr_hold_a_o <= regs_q[IDX_CORR_A][CORR_START_BIT];
      corr_hold_b_o <= regs_q[IDX_CORR_B][CORR_START_BIT];
      sync_mode_o <= sync_mode;
      vref_sel_o <= regs_q[IDX_SYNC_R][VREF_LSB+:3];
      vref_ext_o <= regs_q[IDX_SYNC_R][VREF_LSB+:3] > VREF_LAST_INTERNAL;
      performance_trim_bits_o <= regs_q[IDX_BIAS][TRIM_LSB+:9];
      bias_en_o <= regs_q[IDX_BIAS][BIAS_BIT];
      sync_buf_en_o <= regs_q[IDX_BIAS][SYNC_BUF_BIT];
      unused_buffer_disable_o <= regs_q[IDX_BIAS][UNUSED_BUF_BIT];
      drive_current_o <= regs_q[IDX_DRIVER][DRIVE_LSB+:3];
      driver_switch_o <= regs_q[IDX_DRIVER][SWITCH_LSB+:2];
      termination_o <= regs_q[IDX_DRIVER][TERM_LSB+:2];
      chan_a_clock_out_on_o <= regs_q[IDX_DRIVER][CLK_A_BIT];
      chan_b_clock_out_on_o <= regs_q[IDX_DRIVER][CLK_B_BIT];
      chan_a_overrange_out_on_o <= regs_q[IDX_DRIVER][OVR_A_BIT];
      chan_b_overrange_out_on_o <= regs_q[IDX_DRIVER][OVR_B_BIT];
      lane_mask_a_o <= regs_q[IDX_MASK_A];
      lane_mask_b_o <= regs_q[IDX_MASK_B];
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  logic wr_ok;
  assign wr_ok = rp.wr_stb && !soft_rst;

  a_corr_hold_a: assert property (wr_ok && rp.addr == ADDR_CORR_A |-> ##2
    corr_hold_a_o == $past(rp.wdata[CORR_START_BIT], 2)) else $error("channel a hold wrong");
  a_corr_hold_b: assert property (wr_ok && rp.addr == ADDR_CORR_B |-> ##2
    corr_hold_b_o == $past(rp.wdata[CORR_START_BIT], 2)) else $error("channel b hold wrong");
  a_sync_pins: assert property (regs_q[IDX_SYNC_P][15:2] == 14'h2aaa
    && regs_q[IDX_SYNC_R][15:12] == 4'ha |=> sync_mode_o == SYNC_PINS) else $error("sync mode wrong");
  a_vref_external: assert property (vref_ext_o |-> vref_sel_o > 3'h4) else $error("vref flag wrong");
  a_temp_upper_zero: assert property (u_port.load_q && rp.addr == ADDR_TEMPERATURE |=>
    u_port.out_q[15:9] == 7'h00 && u_port.out_q[8:0] == $past(temp_i)) else $error("temperature read wrong");
  a_soft_reset_all: assert property (soft_rst |=> ##1 lane_mask_a_o == 16'hffff
    && bias_en_o && corr_hold_a_o && drive_current_o == 3'h0) else $error("soft reset incomplete");
  a_sleep_gated: assert property (sleep_state_o != 4'h0 |-> !$past(en_q)) else $error("sleep while enabled");
  a_wake_light: assert property ($rose(pwr_q == PWR_WAKE) && slp_q == SLP_LIGHT |->
    wcnt_q == 19'(WAKE_LIGHT_CYC - 1) && !powered_o) else $error("light wake time wrong");
  a_lane_mask_b: assert property (wr_ok && rp.addr == ADDR_LANE_MASK_B |-> ##2
    lane_mask_b_o == $past(rp.wdata, 2)) else $error("lane mask b wrong");
  a_clock_buf_a: assert property (wr_ok && rp.addr == ADDR_OUTPUT_DRIVER |-> ##2
    chan_a_clock_out_on_o == $past(rp.wdata[CLK_A_BIT], 2)) else $error("clock buffer enable wrong");

  c_soft_reset: cover property (soft_rst);
  c_read_frame: cover property (sdio_oe_o [*4]);
  c_light_wake: cover property (pwr_q == PWR_WAKE && slp_q == SLP_LIGHT ##1 powered_o);
  c_mask_write: cover property (wr_ok && rp.addr == ADDR_LANE_MASK_A);

endmodule // acrb_top

// *** bench/acrb_ctl_model.sv ***
// serial programming controller model facing the register bank
`timescale 1ns/10ps
module acrb_ctl_model (
  input wire logic clk_i, // system clock
  input wire logic sdio_i, // resolved data wire
  output logic sclk_o, // serial clock, still outside frames
  output logic sdenb_n_o, // serial enable, low active
  output logic sdio_o, // data drive value
  output logic sdio_oe_o // data drive enable
);
  // 8 cycles per level gives the 80 ns serial period
  localparam int HALF = 8;

  // idle levels at time zero
  initial begin
    sclk_o = 1'b0;
    sdenb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  // one whole frame: direction bit, 7 address bits, 16 data bits, msb first
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                       output logic [15:0] rd_o);
    logic [23:0] sh;
    sh = {rd, addr, wd};
    rd_o = 16'h0000;
    @(negedge clk_i);
    sdenb_n_o = 1'b0;
    for (int b = 0; b < 24; b++) begin
      sdio_oe_o = !(rd && b >= 8); // release the wire for read data
      sdio_o = sh[23-b];
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b1;
      if (b >= 8) rd_o[23-b] = sdio_i; // sample read data at rising edge
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    sdio_oe_o = 1'b0;
    repeat (HALF) @(negedge clk_i);
    sdenb_n_o = 1'b1; // enable rises between frames
    repeat (2 * HALF) @(negedge clk_i);
  endtask
endmodule // acrb_ctl_model

// *** bench/tb_top.sv ***
// self-checking bench for the converter configuration register bank
`timescale 1ns/10ps
module tb_top;
  import acrb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic ce = 1'b1;
  logic [8:0] temp = 9'h000;
  logic sclk, sdenb_n, c_d, c_oe, d_d, d_oe;
  logic sdio_w;
  logic ha, hb, vx, pw, bi, sb, ub, ca, cb, oa, ob;
  logic [3:0] sm, ss;
  logic [2:0] vs, dc;
  logic [8:0] pt;
  logic [1:0] sw, tm;
  logic [15:0] ma, mb, rv, dv, lm;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [5:0] codes [4] = '{6'h00, SLEEP_CODE_STANDBY, SLEEP_CODE_DEEP, SLEEP_CODE_LIGHT};
  int wk [4] = '{50, 20, WAKE_DEEP_CYC, WAKE_LIGHT_CYC};

  always #2.5 clk = ~clk;
  // wire level: device, then controller, else inverse of the last value
  assign sdio_w = d_oe ? d_d : (c_oe ? c_d : ~c_d);

  acrb_top #(.WAKE_SHUT_CYCLES(50), .WAKE_STBY_CYCLES(20)) dut_u (.clk_i(clk), .sys_rst_i(rst),
    .ce_i(ce), .sclk_i(sclk), .sdenb_n_i(sdenb_n), .sdio_i(sdio_w), .sdio_o(d_d), .sdio_oe_o(d_oe),
    .enable_i(en), .temp_i(temp), .corr_hold_a_o(ha), .corr_hold_b_o(hb), .sync_mode_o(sm),
    .vref_sel_o(vs), .vref_ext_o(vx), .sleep_state_o(ss), .powered_o(pw), .performance_trim_bits_o(pt),
    .bias_en_o(bi), .sync_buf_en_o(sb), .unused_buffer_disable_o(ub), .drive_current_o(dc),
    .driver_switch_o(sw), .termination_o(tm), .chan_a_clock_out_on_o(ca), .chan_b_clock_out_on_o(cb),
    .chan_a_overrange_out_on_o(oa), .chan_b_overrange_out_on_o(ob), .lane_mask_a_o(ma),
    .lane_mask_b_o(mb));

  acrb_ctl_model ctl_u (.clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk), .sdenb_n_o(sdenb_n),
    .sdio_o(c_d), .sdio_oe_o(c_oe));

  task automatic summarize();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input acrb_addr_t a, input acrb_word_t d);
    logic [15:0] x;
    ctl_u.frame(1'b0, a, d, x);
  endtask

  task automatic rd(input acrb_addr_t a, output acrb_word_t d);
    ctl_u.frame(1'b1, a, 16'h0000, d);
  endtask

  // controller keeps the bits the device asks it to hold
  function automatic acrb_word_t legal(int i, acrb_word_t d);
    if (i == IDX_CORR_A || i == IDX_CORR_B) return d | 16'h0b18;
    if (i == IDX_BIAS) return d | 16'hff80;
    if (i == IDX_MASK_A || i == IDX_MASK_B) return d & 16'h2fff;
    return d;
  endfunction

  // every stored register and every register-driven control output at its default
  task automatic chk_defaults();
    acrb_word_t x;
    for (int i = 0; i < REG_COUNT; i++) begin
      rd(REG_ADDR[i], x);
      check("reset_value", x, REG_RST[i] | REG_ONES[i]);
    end
    check("lane_masks", {ma, mb}, 32'hffff_ffff);
    check("corr_holds", {ha, hb}, 2'b11);
    check("sync_mode", sm, 4'h4);
    check("vref", {vs, vx}, 4'h0);
    check("bias_group", {pt, bi, sb, ub}, 12'hfff);
    check("out_buffers", {dc, ca, cb, oa, ob}, 7'h0f);
    check("drv_range", {sw, tm}, 4'h4);
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end

  // main sequence
  initial begin
    void'($urandom(74));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_defaults();
    for (int i = 0; i < REG_COUNT; i++) begin
      dv = legal(i, 16'($urandom));
      wr(REG_ADDR[i], dv);
      rd(REG_ADDR[i], rv);
      check("readback", rv, (dv & REG_MASK[i]) | REG_ONES[i]);
      if (i == IDX_CORR_A) check("corr_hold_a", ha, dv[14]);
      if (i == IDX_CORR_B) check("corr_hold_b", hb, dv[14]);
      if (i == IDX_SLEEP) check("sleep_awake", {ss, pw}, 5'h01);
      if (i == IDX_BIAS) check("bias_group", {pt, bi, sb, ub}, dv[15:4]);
      if (i == IDX_DRIVER) check("out_buffers", {dc, ca, cb, oa, ob}, {dv[15:13], dv[4:3], dv[1:0]});
      if (i == IDX_DRIVER) check("drv_range", {sw, tm}, dv[12:9]);
      if (i == IDX_MASK_A) check("lane_mask_a", ma, dv);
      if (i == IDX_MASK_B) check("lane_mask_b", mb, dv);
    end
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_SYNC_REFERENCE, 16'ha000 | 16'(v << 4));
      check("vref", {vs, vx}, {3'(v), v > 4});
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SYNC_PRIMARY, {{7{2'(c)}}, 2'b00});
      wr(ADDR_SYNC_REFERENCE, {{2{2'(c)}}, 12'h000});
      check("sync_mode", sm, 4'h1 << c);
    end
    wr(ADDR_SYNC_PRIMARY, 16'haaa8);
    wr(ADDR_SYNC_REFERENCE, 16'h5000);
    check("sync_disagree", sm, 4'h8);
    temp = 9'($urandom);
    wr(ADDR_TEMPERATURE, 16'hffff);
    rd(ADDR_TEMPERATURE, rv);
    check("temperature", rv, {7'h00, temp});
    rd(7'h10, rv);
    check("unmapped", rv, 16'h0000);
    lm = ma;
    wr(ADDR_SOFT_RESET, 16'h1234);
    check("wrong_key", ma, lm);
    wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
    rd(ADDR_SOFT_RESET, rv);
    check("reset_self_clear", rv, 16'h0000);
    chk_defaults();
    // clock enable low freezes the enable synchroniser, so no sleep entry
    ce = 1'b0;
    en = 1'b0;
    repeat (8) @(negedge clk);
    check("ce_freeze", {ss, pw}, 5'h01);
    en = 1'b1;
    repeat (2) @(negedge clk);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    check("ce_release", {ss, pw}, 5'h01);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SLEEP_SELECT, {codes[k], 10'h000});
      check("sleep_idle", ss, 4'h0);
      en = 1'b0;
      repeat (8) @(negedge clk);
      check("sleep_enter", {ss, pw}, {4'h1 << k, 1'b0});
      en = 1'b1;
      n = 0;
      while (pw !== 1'b1 && n < wk[k] + 20) begin
        @(negedge clk);
        n++;
      end
      check("wake_time", n >= wk[k] && n <= wk[k] + 8, 1'b1);
    end
    summarize();
  end
endmodule // tb_top
